// file: core/sdl_link_if.sv
/*
  interface carrying a completed word from the shift-clock side to the core.
  assumes the word is held stable while the full flag on word_tgl is being synchronised.
*/
`timescale 1ns/1ns
`default_nettype none
interface sdl_link_if;
  logic [7:0] word;
  logic word_tgl;
  modport link (output word, output word_tgl);
  modport core (input word, input word_tgl);
endinterface
`default_nettype wire

// file: core/sdl_pkg.sv
/*
  package of the serial converter load interface: word size, counter widths,
  reset values and link timing figures.
  assumes a system clock of 250 MHz and a host shift clock of at most 50 MHz.
*/
package sdl_pkg;
  localparam int SDL_WORD_BITS = 8;
  localparam int SDL_CNT_W = 4;
  localparam logic [3:0] SDL_CNT_RST = 4'h0;
  localparam logic [3:0] SDL_CNT_LAST = 4'h7;
  localparam logic [3:0] SDL_CNT_FULL = 4'h8;
  localparam logic [7:0] SDL_CODE_RST = 8'h00;
  localparam logic [7:0] SDL_CODE_MAX = 8'hFF;
  localparam int SDL_CLK_PERIOD_NS = 4;
  localparam int SDL_SCLK_MAX_MHZ = 50;
  localparam int SDL_SCLK_MIN_PERIOD_NS = 20;
  localparam int SDL_SCLK_MIN_PERIOD_CYC = (SDL_SCLK_MIN_PERIOD_NS + SDL_CLK_PERIOD_NS - 1) / SDL_CLK_PERIOD_NS;
endpackage

// file: core/sdl_shift.sv
/*
  shift-clock side of the load interface: bit counter and input shift register.
  assumes frame_n and serial_data_in are launched by the host on its own clock.
*/
`timescale 1ns/1ns
`default_nettype none
module sdl_shift
  import sdl_pkg::*;
(
  // link pins
  input wire logic sclk,
  input wire logic frame_n,
  input wire logic serial_data_in,
  // to core
  sdl_link_if.link lnk
);
  typedef struct packed {
    logic [7:0] word;
  } sdl_shift_t;

  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  sdl_shift_t st_reg;
  sdl_shift_t st_next;
  logic take;

  // counter cleared by frame high, since sclk may stand still between frames
  assign take = !frame_n && (cnt_reg < SDL_CNT_FULL);

  always_comb begin
    cnt_next = cnt_reg;
    st_next = st_reg;
    if (take) begin
      cnt_next = cnt_reg + 4'h1;
      st_next.word = {st_reg.word[6:0], serial_data_in};
    end
  end

  always_ff @(negedge sclk or posedge frame_n) begin
    if (frame_n) begin
      cnt_reg <= SDL_CNT_RST;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // word survives the end of frame so a later load still sees it
  always_ff @(negedge sclk) begin
    st_reg <= st_next;
  end

  assign lnk.word = st_reg.word;
  // a level, not a toggle: this side has no reset to start a toggle from
  assign lnk.word_tgl = (cnt_reg == SDL_CNT_FULL);
endmodule
`default_nettype wire

// file: core/sdl_top.sv
/*
  serial converter load interface: takes 8-bit words from the host link and
  moves them into the converter latch on a load fall or automatically.
  assumes latch_update_n is asynchronous to clk; sclk is the host's clock.
*/
// Summary of operation
// - sample data on each shift clock falling edge
// - input register holds exactly eight bits
// - frame select high ignores clock and data
// - frame is eight bits on eight falling edges
// - load falling copies input register to latch
// - load held low updates after eighth edge
// - code is unsigned binary 0 to 255
`timescale 1ns/1ns
`default_nettype none
module sdl_top
  import sdl_pkg::*;
(
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // host link
  input wire logic sclk,
  input wire logic frame_n,
  input wire logic serial_data_in,
  input wire logic latch_update_n,
  // converter side
  output logic [7:0] dac_code,
  output logic dac_update,
  output logic [7:0] input_word,
  output logic word_ready
);
  typedef struct packed {
    logic ld_s1;
    logic ld_s2;
    logic ld_s3;
    logic tg_s1;
    logic tg_s2;
    logic tg_s3;
    logic [7:0] in_word;
    logic [7:0] dac;
    logic upd;
    logic rdy;
  } sdl_core_t;

  sdl_link_if lnk ();
  sdl_core_t st_reg;
  sdl_core_t st_next;
  logic word_evt;
  logic ld_fall;
  logic [7:0] fresh;

  sdl_shift u_shift (
    .sclk(sclk),
    .frame_n(frame_n),
    .serial_data_in(serial_data_in),
    .lnk(lnk.link)
  );

  // full flag rises once per word; edges judged from second and third stages
  assign word_evt = st_reg.tg_s2 && !st_reg.tg_s3;
  assign ld_fall = st_reg.ld_s3 && !st_reg.ld_s2;
  // same sync depth on both paths, so a load at the last edge sees the new word
  assign fresh = word_evt ? lnk.word : st_reg.in_word;

  always_comb begin
    st_next = st_reg;
    st_next.ld_s1 = latch_update_n;
    st_next.ld_s2 = st_reg.ld_s1;
    st_next.ld_s3 = st_reg.ld_s2;
    st_next.tg_s1 = lnk.word_tgl;
    st_next.tg_s2 = st_reg.tg_s1;
    st_next.tg_s3 = st_reg.tg_s2;
    st_next.upd = 1'b0;
    st_next.rdy = word_evt;
    if (word_evt) begin
      st_next.in_word = lnk.word;
    end
    if (ld_fall) begin
      st_next.dac = fresh;
      st_next.upd = 1'b1;
    end else if (word_evt && !st_reg.ld_s2) begin
      st_next.dac = lnk.word;
      st_next.upd = 1'b1;
    end
    if (sys_rst) begin
      st_next = '0;
      st_next.ld_s1 = 1'b1;
      st_next.ld_s2 = 1'b1;
      st_next.ld_s3 = 1'b1;
      st_next.in_word = SDL_CODE_RST;
      st_next.dac = SDL_CODE_RST;
    end
  end

  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  assign dac_code = st_reg.dac;
  assign dac_update = st_reg.upd;
  assign input_word = st_reg.in_word;
  assign word_ready = st_reg.rdy;
endmodule
`default_nettype wire

// file: test/sdl_host.sv
/* host model: sends frames msb first; assumes the bench calls send */
`timescale 1ns/1ns
`default_nettype none
module sdl_host (
  // link pins
  output logic sclk = 1'h1,
  output logic frame_n = 1'h0,
  output logic serial_data_in = 1'h0
);
  // early rise clears the unreset bit counter before the first frame
  initial begin
    #1 frame_n = 1'h1;
  end
  // clock stands high between frames; short n gives a cut frame
  task automatic send(input logic [7:0] w, input int n);
    frame_n = 1'h0;
    for (int i = 7; i > 7 - n; i--) begin
      serial_data_in = w[i];
      #32 sclk = 1'h0;
      #32 sclk = 1'h1;
    end
    #8 frame_n = 1'h1;
    serial_data_in = ~serial_data_in;
    #40;
  endtask
endmodule
`default_nettype wire

// file: test/sdl_top_asserts.sv
/* port checker of sdl_top; assumes async pins are judged as sampled on clk */
`timescale 1ns/1ns
`default_nettype none
module sdl_chk (
  // watched ports
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic frame_n,
  input wire logic latch_update_n,
  input wire logic [7:0] dac_code,
  input wire logic dac_update,
  input wire logic [7:0] input_word,
  input wire logic word_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_wr; word_ready |=> !word_ready; endproperty
  a_wr: assert property (p_wr) else $error("wr");
  property p_up; dac_update |=> !dac_update; endproperty
  a_up: assert property (p_up) else $error("up");
  property p_uv; dac_update |-> dac_code == input_word; endproperty
  a_uv: assert property (p_uv) else $error("uv");
  property p_ld; $fell(latch_update_n) |-> ##[1:5] dac_update; endproperty
  a_ld: assert property (p_ld) else $error("ld");
  property p_au; (!latch_update_n [*4] ##0 word_ready) |-> dac_update; endproperty
  a_au: assert property (p_au) else $error("au");
  property p_iw; $changed(input_word) |-> word_ready; endproperty
  a_iw: assert property (p_iw) else $error("iw");
  property p_dc; $changed(dac_code) |-> dac_update; endproperty
  a_dc: assert property (p_dc) else $error("dc");
  // idle select long enough that no answer can still be in flight
  property p_fr; frame_n [*8] |-> !word_ready; endproperty
  a_fr: assert property (p_fr) else $error("fr");
endmodule
bind sdl_top sdl_chk i_chk (.*);
`default_nettype wire

// file: test/test_sdl_top.sv
/* bench of sdl_top; assumes the host model and checker files */
`timescale 1ns/1ns
`default_nettype none
module test_serial_dac_load_interface;
  logic clk = 1'h0, sys_rst = 1'h1, latch_update_n = 1'h1;
  logic sclk, frame_n, serial_data_in, dac_update, word_ready;
  logic [7:0] dac_code, input_word;
  int n_errors = 0, check_count = 0;
  logic [7:0] n_ready = 8'h00, n_upd = 8'h00;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (!sys_rst && word_ready) n_ready <= n_ready + 8'h01;
    if (!sys_rst && dac_update) n_upd <= n_upd + 8'h01;
  end
  sdl_top i_dut (.*);
  sdl_host i_host (.*);
  task automatic check(input string nm, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s exp %h got %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_link();
    check("code", dac_code, 8'h00);
    i_host.send(8'hA5, 8);
    check("word", input_word, 8'hA5);
    i_host.send(8'h3C, 5);
    check("word", input_word, 8'hA5);
    i_host.send(8'h3C, 8);
    check("word", input_word, 8'h3C);
    check("code", dac_code, 8'h00);
  endtask
  // load stays low afterwards, so the last frame runs in auto mode
  task automatic t_load();
    @(posedge clk);
    #1 latch_update_n = 1'h0;
    #24;
    check("code", dac_code, 8'h3C);
    i_host.send(8'hFF, 8);
    check("code", dac_code, 8'hFF);
    check("ready", n_ready, 8'h03);
    check("upd", n_upd, 8'h02);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1 sys_rst = 1'h0;
    t_link();
    t_load();
    stop_test();
  end
  initial begin
    #9000;
    n_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
